// ===== mbs_top.sv
// Top of the bus status, lock and request/grant logic
`timescale 1ns/1ps
`default_nettype none
module mbs_top
    import mbs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       config_strap,
    input  wire logic       ready_pin,
    input  wire logic       cyc_req,
    input  wire logic [2:0] cyc_type,
    input  wire logic       cyc_low_byte,
    input  wire logic       cyc_first_interrupt_ack_strobe,
    input  wire logic       lock_prefix,
    input  wire logic       instr_done,
    input  wire logic [1:0] queue_op,
    input  wire logic       rqgt_primary_in,
    input  wire logic       rqgt_secondary_in,
    output var  logic       rqgt_primary_out,
    output var  logic       rqgt_primary_oe,
    output var  logic       rqgt_secondary_out,
    output var  logic       rqgt_secondary_oe,
    output var  logic [2:0] bus_cycle_status,
    output var  logic       status_oe,
    output var  logic       status_low_line,
    output var  logic       io_mem_sel,
    output var  logic       transmit_receive_dir,
    output var  logic       lock_n,
    output var  logic       lock_oe,
    output var  logic       hold_ack_out,
    output var  logic       bus_float,
    output var  logic [1:0] queue_track_status,
    output var  logic       cyc_ack,
    output var  logic       cyc_end
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    mbs_chan_if   ch0 ();
    mbs_chan_if   ch1 ();

    mbs_bus_st_t  st_r;
    mbs_bus_st_t  st_nxt;
    logic [2:0]   typ_r;
    logic [2:0]   status_nxt;
    logic         low_r;
    logic         inta1_r;
    logic         early_r;
    logic         lock_r;
    logic         lock_nxt;
    logic         owner_r;
    logic         rdy_s1_r;
    logic         rdy_s2_r;
    logic         rdy_s3_r;
    logic         ready_r;
    logic         strap_s1_r;
    logic         strap_s2_r;
    logic         strap_s3_r;
    logic [2:0]   strap_fill_r;
    logic         strap_done_r;
    logic         min_mode_r;
    logic         any_req;
    logic         done_any;
    logic         grant_ok;
    logic         accept;
    logic         float_nxt;
    logic         active_nxt;

    //------------------------------------------------------------
    // Helper
    //------------------------------------------------------------
    function automatic logic is_float(input mbs_bus_st_t s);
        is_float = (s == BS_TG) || (s == BS_TH);
    endfunction

    //------------------------------------------------------------
    // Request/grant lines and queue status
    //------------------------------------------------------------
    mbs_rqgt_chan u_ch0 (
        .clk     (clk),
        .arst_n  (arst_n),
        .pin_in  (rqgt_primary_in),
        .pin_out (rqgt_primary_out),
        .pin_oe  (rqgt_primary_oe),
        .cif     (ch0.chan)
    );

    mbs_rqgt_chan u_ch1 (
        .clk     (clk),
        .arst_n  (arst_n),
        .pin_in  (rqgt_secondary_in),
        .pin_out (rqgt_secondary_out),
        .pin_oe  (rqgt_secondary_oe),
        .cif     (ch1.chan)
    );

    mbs_qstat u_qs (
        .clk      (clk),
        .arst_n   (arst_n),
        .queue_op (queue_op),
        .qs       (queue_track_status)
    );

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    // Ready and strap come from outside; a level counts once stages 2 and 3 agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_s1_r <= 1'b0;
            rdy_s2_r <= 1'b0;
            rdy_s3_r <= 1'b0;
            ready_r  <= 1'b0;
        end else begin
            rdy_s1_r <= ready_pin;
            rdy_s2_r <= rdy_s1_r;
            rdy_s3_r <= rdy_s2_r;
            if (rdy_s2_r == rdy_s3_r) ready_r <= rdy_s3_r;
        end
    end

    // Strap is caught once after release and then frozen
    // Fill bits keep reset zeros in the stages from passing for a strap level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_s1_r   <= 1'b0;
            strap_s2_r   <= 1'b0;
            strap_s3_r   <= 1'b0;
            strap_fill_r <= 3'h0;
            strap_done_r <= 1'b0;
            min_mode_r   <= 1'b0;
        end else begin
            strap_s1_r   <= config_strap;
            strap_s2_r   <= strap_s1_r;
            strap_s3_r   <= strap_s2_r;
            strap_fill_r <= {strap_fill_r[1:0], 1'b1};
            if (!strap_done_r && strap_fill_r[2] && strap_s2_r == strap_s3_r) begin
                strap_done_r <= 1'b1;
                min_mode_r   <= strap_s3_r;
            end
        end
    end

    //------------------------------------------------------------
    // Arbitration
    //------------------------------------------------------------
    assign any_req  = ch0.req || ch1.req;
    assign done_any = owner_r ? ch1.done : ch0.done;

    // Lock blocks release even on an idle bus; no grant until strap is known
    always_comb begin
        grant_ok = 1'b0;
        if (strap_done_r && !min_mode_r && !lock_r) begin
            if (st_r == BS_TI)
                grant_ok = 1'b1; // R13
            else if (st_r == BS_T4)
                grant_ok = early_r && !low_r && !inta1_r; // R12
        end
    end

    assign ch0.grant = grant_ok && ch0.req; // R5
    assign ch1.grant = grant_ok && !ch0.req && ch1.req; // R5

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) owner_r <= 1'b0;
        else if (ch0.grant) owner_r <= 1'b0;
        else if (ch1.grant) owner_r <= 1'b1;
    end

    //------------------------------------------------------------
    // Bus state sequencer
    //------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            BS_TI, BS_T4: begin
                if (grant_ok && any_req) st_nxt = BS_TG; // R8
                else if (cyc_req)        st_nxt = BS_TS; // R3
                else                     st_nxt = BS_TI;
            end
            BS_TS:        st_nxt = BS_T1;
            BS_T1:        st_nxt = BS_T2;
            BS_T2:        st_nxt = BS_T3;
            BS_T3, BS_TW: st_nxt = ready_r ? BS_T4 : BS_TW;
            BS_TG:        st_nxt = BS_TH; // R8
            BS_TH:        st_nxt = done_any ? BS_T4 : BS_TH; // R10
            default:      st_nxt = BS_TI;
        endcase
    end

    assign accept     = (st_nxt == BS_TS);
    assign float_nxt  = is_float(st_nxt);
    assign active_nxt = (st_nxt == BS_TS) || (st_nxt == BS_T1) || (st_nxt == BS_T2);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) st_r <= BS_TI;
        else         st_r <= st_nxt;
    end

    // Cycle attributes are held for the whole cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            typ_r   <= ST_PASSIVE;
            low_r   <= 1'b0;
            inta1_r <= 1'b0;
        end else if (accept) begin
            typ_r   <= cyc_type;
            low_r   <= cyc_low_byte;
            inta1_r <= cyc_first_interrupt_ack_strobe;
        end
    end

    // A request pending at the start counts as early
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            early_r <= 1'b0;
        end else if (accept) begin
            early_r <= any_req; // R14
        end else if (st_r == BS_TS || st_r == BS_T1 || st_r == BS_T2) begin
            early_r <= early_r || any_req; // R12
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_ack <= 1'b0;
            cyc_end <= 1'b0;
        end else begin
            cyc_ack <= accept;
            cyc_end <= (st_nxt == BS_T4) && (st_r != BS_TH);
        end
    end

    //------------------------------------------------------------
    // Status outputs
    //------------------------------------------------------------
    // Code is fed straight to the external controller for its strobes
    assign status_nxt = !active_nxt ? ST_PASSIVE :
                        (st_nxt == BS_TS) ? cyc_type : typ_r; // R2 R3 R4

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_cycle_status <= ST_PASSIVE;
            status_oe        <= 1'b1;
        end else begin
            bus_cycle_status <= status_nxt; // R2
            status_oe        <= !float_nxt; // R9 R20
        end
    end

    // Minimum-mode lines hold from announce to the next announce
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_low_line      <= RST_LOW;
            io_mem_sel           <= 1'b0;
            transmit_receive_dir <= 1'b0;
        end else if (!min_mode_r) begin
            status_low_line      <= 1'b1; // R19
        end else if (accept) begin
            status_low_line      <= cyc_type[0]; // R1
            io_mem_sel           <= !cyc_type[2];
            transmit_receive_dir <= cyc_type[1];
        end
    end

    //------------------------------------------------------------
    // Hold acknowledge and lock
    //------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_ack_out <= 1'b0;
            bus_float    <= 1'b0;
        end else begin
            hold_ack_out <= float_nxt; // R20
            bus_float    <= float_nxt; // R9
        end
    end

    // Set wins so a prefix in the completing clock is not lost
    assign lock_nxt = lock_prefix || (lock_r && !instr_done);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_r  <= 1'b0;
            lock_n  <= 1'b1;
            lock_oe <= 1'b1;
        end else begin
            lock_r  <= lock_nxt; // R15
            lock_n  <= !lock_nxt;
            lock_oe <= !float_nxt; // R16
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_active_t1t2;
        (st_r == BS_T1) |-> (bus_cycle_status == typ_r) ##1 (bus_cycle_status == typ_r);
    endproperty
    a_active_t1t2: assert property (p_active_t1t2) else $error("status not active"); // R2

    property p_passive_end;
        (st_r == BS_T3 || st_r == BS_TW) |-> (bus_cycle_status == ST_PASSIVE);
    endproperty
    a_passive_end: assert property (p_passive_end) else $error("status not passive"); // R2

    property p_start_in_t4;
        $changed(bus_cycle_status) && (bus_cycle_status != ST_PASSIVE)
            |-> (st_r == BS_TS) ##1 (st_r == BS_T1);
    endproperty
    a_start_in_t4: assert property (p_start_in_t4) else $error("cycle start misplaced"); // R3

    property p_prio;
        (ch0.req && ch1.req && grant_ok) |=> rqgt_primary_oe && !rqgt_secondary_oe;
    endproperty
    a_prio: assert property (p_prio) else $error("secondary won over primary"); // R5

    property p_grant_pulse;
        $rose(hold_ack_out) |-> (rqgt_primary_oe ^ rqgt_secondary_oe)
            ##1 !(rqgt_primary_oe || rqgt_secondary_oe) && hold_ack_out;
    endproperty
    a_grant_pulse: assert property (p_grant_pulse) else $error("grant pulse wrong"); // R8

    property p_float;
        hold_ack_out |-> bus_float && !status_oe && !lock_oe;
    endproperty
    a_float: assert property (p_float) else $error("bus driven in hold"); // R9

    property p_reclaim;
        (st_r == BS_TH && done_any) |=> (st_r == BS_T4) && !bus_float && status_oe;
    endproperty
    a_reclaim: assert property (p_reclaim) else $error("reclaim late"); // R10

    property p_release_cond;
        (st_r == BS_T4 && (low_r || inta1_r || lock_r || !early_r)) |=> !hold_ack_out;
    endproperty
    a_release_cond: assert property (p_release_cond) else $error("bad release"); // R12

    property p_idle_release;
        (st_r == BS_TI && any_req && !lock_r && strap_done_r && !min_mode_r)
            |=> hold_ack_out;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("idle grant late"); // R13

    property p_lock;
        lock_prefix |=> !lock_n [*1] ##0 lock_r;
    endproperty
    a_lock: assert property (p_lock) else $error("lock not asserted"); // R15

    property p_low_high;
        (strap_done_r && !min_mode_r) |=> status_low_line;
    endproperty
    a_low_high: assert property (p_low_high) else $error("low line not high"); // R19

    c_grant0: cover property ($rose(rqgt_primary_oe));
    c_grant1: cover property ($rose(rqgt_secondary_oe));
    c_wait:   cover property (st_r == BS_TW ##1 st_r == BS_T4);
    c_locked: cover property (lock_r && st_r == BS_T4 && any_req);

endmodule // mbs_top
`default_nettype wire

// ===== mbs_pkg.sv
// Shared constants and types for the bus status and grant block
//------------------------------------------------------------
// Overview of operation
// [R1] Minimum mode: low status line decodes cycle
// [R2] Status active T4,T1,T2; passive T3/Tw
// [R3] Status change in T4 starts cycle
// [R4] Controller decodes strobes only from status
// [R5] Two request/grant lines; primary wins
// [R6] Pulled-up line never makes a request
// [R7] Master requests with one-clock low pulse
// [R8] Grant pulse in T4/idle, then hold
// [R9] Bus interface disconnected during hold acknowledge
// [R10] Third pulse ends hold; reclaim into T4
// [R11] Three pulses, then one idle clock
// [R12] Release at T4 only if four conditions
// [R13] Idle bus may release next clock
// [R14] Idle request counts as early for cycle
// [R15] Lock output active through next instruction
// [R16] Lock output floats during hold acknowledge
// [R17] Queue status codes 00,01,10,11
// [R18] Queue status valid the following clock
// [R19] Maximum mode: low line held high
// [R20] Float bus together with hold acknowledgement
// [R21] Pulses driven and sampled on clk
//------------------------------------------------------------
package mbs_pkg;

    //------------------------------------------------------------
    // Encodings and reset values
    //------------------------------------------------------------
    localparam logic [2:0] ST_PASSIVE = 3'h7;
    localparam logic [1:0] QS_NOP     = 2'h0;
    localparam logic [1:0] QS_FIRST   = 2'h1;
    localparam logic [1:0] QS_EMPTY   = 2'h2;
    localparam logic [1:0] QS_NEXT    = 2'h3;
    localparam logic       RST_LOW    = 1'h1;

    //------------------------------------------------------------
    // State types
    //------------------------------------------------------------
    typedef enum logic [8:0] {
        BS_TI = 9'h001, BS_TS = 9'h002, BS_T1 = 9'h004,
        BS_T2 = 9'h008, BS_T3 = 9'h010, BS_TW = 9'h020,
        BS_T4 = 9'h040, BS_TG = 9'h080, BS_TH = 9'h100
    } mbs_bus_st_t;

    typedef enum logic [3:0] {
        CH_IDLE = 4'h1, CH_PEND = 4'h2, CH_HOLD = 4'h4, CH_GAP = 4'h8
    } mbs_ch_st_t;

endpackage

// ===== mbs_chan_if.sv
// Handshake between the bus sequencer and one request/grant line
`timescale 1ns/1ps
`default_nettype none
interface mbs_chan_if;
    logic req;
    logic grant;
    logic done;
    modport core (input req, input done, output grant);
    modport chan (output req, output done, input grant);
endinterface // mbs_chan_if
`default_nettype wire

// ===== mbs_rqgt_chan.sv
// One request/grant line: pulse sequence tracker and pin driver
`timescale 1ns/1ps
`default_nettype none
module mbs_rqgt_chan
    import mbs_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic pin_in,
    output var  logic pin_out,
    output var  logic pin_oe,
    mbs_chan_if.chan  cif
);
    mbs_ch_st_t st_r;
    logic       pulse;

    // Pin is same-clock logic; only a low not of our making counts
    assign pulse    = !pin_in && !pin_oe; // R6 R7 R21
    assign cif.req  = (st_r == CH_PEND);
    assign cif.done = (st_r == CH_HOLD) && pulse; // R10

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= CH_IDLE;
        end else begin
            case (st_r)
                CH_IDLE: if (pulse) st_r <= CH_PEND;
                CH_PEND: if (cif.grant) st_r <= CH_HOLD;
                CH_HOLD: if (pulse) st_r <= CH_GAP;
                CH_GAP:  st_r <= CH_IDLE; // R11
                default: st_r <= CH_IDLE;
            endcase
        end
    end

    // Grant pulse is exactly one clock low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_oe  <= 1'b0;
            pin_out <= 1'b1;
        end else begin
            pin_oe  <= cif.grant; // R8
            pin_out <= !cif.grant;
        end
    end
endmodule // mbs_rqgt_chan
`default_nettype wire

// ===== mbs_qstat.sv
// Queue status register
`timescale 1ns/1ps
`default_nettype none
module mbs_qstat
    import mbs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] queue_op,
    output var  logic [1:0] qs
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) qs <= QS_NOP;
        else         qs <= queue_op; // R17 R18
    end

    property p_qs_follow;
        @(posedge clk) disable iff (!arst_n)
        (queue_op == QS_FIRST) |=> (qs == QS_FIRST) ##1 (qs == $past(queue_op));
    endproperty
    a_qs_follow: assert property (p_qs_follow) else $error("queue status late"); // R18
endmodule // mbs_qstat
`default_nettype wire

// ===== mbs_bus_master.sv
// Model of another local bus master on one request/grant line
`timescale 1ns/1ps
`default_nettype none
module mbs_bus_master (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       start,
    input  wire logic [3:0] hold_len,
    input  wire logic       line_in,
    output var  logic       drive_low,
    output var  logic       granted,
    output var  logic       done
);
    typedef enum logic [1:0] {MS_IDLE, MS_WAIT, MS_HOLD, MS_GAP} mbs_mst_st_t;
    mbs_mst_st_t st_r;
    logic [3:0]  cnt_r;

    // Open-drain style: only ever pulls low, pull-up does the rest
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r      <= MS_IDLE;
            cnt_r     <= 4'h0;
            drive_low <= 1'b0;
            granted   <= 1'b0;
            done      <= 1'b0;
        end else begin
            drive_low <= 1'b0;
            done      <= 1'b0;
            case (st_r)
                MS_IDLE: if (start) begin
                    drive_low <= 1'b1;
                    st_r      <= MS_WAIT;
                end
                MS_WAIT: if (!drive_low && !line_in) begin
                    granted <= 1'b1;
                    cnt_r   <= hold_len;
                    st_r    <= MS_HOLD;
                end
                MS_HOLD: if (cnt_r == 4'h0) begin
                    drive_low <= 1'b1;
                    granted   <= 1'b0;
                    done      <= 1'b1;
                    st_r      <= MS_GAP;
                end else begin
                    cnt_r <= cnt_r - 4'h1;
                end
                default: st_r <= MS_IDLE;
            endcase
        end
    end
endmodule // mbs_bus_master
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the bus status and grant block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mbs_pkg::*;
    logic       clk, arst_n, config_strap, ready_pin, cyc_req, cyc_low_byte, cyc_first_interrupt_ack_strobe;
    logic       lock_prefix, instr_done, p_start, s_start;
    logic [2:0] cyc_type, bus_cycle_status;
    logic [1:0] queue_op, queue_track_status;
    logic       p_out, p_oe, s_out, s_oe, status_oe, status_low_line, io_mem_sel;
    logic       transmit_receive_dir, lock_n, lock_oe, hold_ack_out, bus_float;
    logic       cyc_ack, cyc_end, p_low, s_low, p_done, s_done;
    wire        rq_p, rq_s;
    int         err_count = 0;
    int         total_checks = 0;

    // Pull-up: a released line reads high
    assign rq_p = p_oe ? p_out : (p_low ? 1'b0 : 1'b1);
    assign rq_s = s_oe ? s_out : (s_low ? 1'b0 : 1'b1);

    mbs_top i_dut (.clk(clk), .arst_n(arst_n), .config_strap(config_strap),
        .ready_pin(ready_pin), .cyc_req(cyc_req), .cyc_type(cyc_type),
        .cyc_low_byte(cyc_low_byte), .cyc_first_interrupt_ack_strobe(cyc_first_interrupt_ack_strobe),
        .lock_prefix(lock_prefix), .instr_done(instr_done), .queue_op(queue_op),
        .rqgt_primary_in(rq_p), .rqgt_secondary_in(rq_s), .rqgt_primary_out(p_out),
        .rqgt_primary_oe(p_oe), .rqgt_secondary_out(s_out), .rqgt_secondary_oe(s_oe),
        .bus_cycle_status(bus_cycle_status), .status_oe(status_oe),
        .status_low_line(status_low_line), .io_mem_sel(io_mem_sel),
        .transmit_receive_dir(transmit_receive_dir), .lock_n(lock_n), .lock_oe(lock_oe),
        .hold_ack_out(hold_ack_out), .bus_float(bus_float),
        .queue_track_status(queue_track_status), .cyc_ack(cyc_ack), .cyc_end(cyc_end));
    mbs_bus_master i_mp (.clk(clk), .arst_n(arst_n), .start(p_start), .hold_len(4'h3),
        .line_in(rq_p), .drive_low(p_low), .granted(), .done(p_done));
    mbs_bus_master i_ms (.clk(clk), .arst_n(arst_n), .start(s_start), .hold_len(4'h6),
        .line_in(rq_s), .drive_low(s_low), .granted(), .done(s_done));

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic strap);
        arst_n = 1'b0;
        config_strap = strap;
        repeat (5) step();
        arst_n = 1'b1;
        repeat (4) step();
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task automatic run_cycle(input logic [2:0] typ);
        int n;
        cyc_type = typ;
        cyc_req = 1'b1;
        n = 0;
        step();
        while (cyc_ack !== 1'b1 && n < 12) begin step(); n++; end
        cyc_req = 1'b0;
        chk(cyc_ack, 1'b1, "cycle accepted");
        chk(bus_cycle_status, typ, "status announce");
        step();
        chk(bus_cycle_status, typ, "status T1");
        step();
        chk(bus_cycle_status, typ, "status T2");
        step();
        chk(bus_cycle_status, ST_PASSIVE, "status T3");
        n = 0;
        while (cyc_end !== 1'b1 && n < 12) begin step(); n++; end
        chk(cyc_end, 1'b1, "cycle ended");
        chk(bus_cycle_status, ST_PASSIVE, "status T4 idle");
    endtask
    task automatic serve(input logic sec);
        int n;
        n = 0;
        while (hold_ack_out !== 1'b1 && n < 20) begin step(); n++; end
        chk(hold_ack_out, 1'b1, "hold acknowledge");
        chk(sec ? s_oe : p_oe, 1'b1, "grant on requesting line");
        chk(sec ? s_out : p_out, 1'b0, "grant pulse low");
        chk(sec ? p_oe : s_oe, 1'b0, "no grant on other line");
        chk(bus_float, 1'b1, "bus floated with acknowledge");
        chk(status_oe, 1'b0, "status floated");
        chk(lock_oe, 1'b0, "lock floated");
        step();
        chk(sec ? s_oe : p_oe, 1'b0, "grant one clock wide");
        n = 0;
        while ((sec ? s_done : p_done) !== 1'b1 && n < 20) begin
            chk(hold_ack_out, 1'b1, "hold kept");
            step();
            n++;
        end
        step();
        chk(hold_ack_out, 1'b0, "bus reclaimed");
        chk(status_oe, 1'b1, "status driven again");
        repeat (2) step();
    endtask
    task automatic t_basic();
        chk(bus_cycle_status, ST_PASSIVE, "status after reset");
        chk(lock_n, 1'b1, "lock after reset");
        repeat (10) begin
            step();
            chk(hold_ack_out, 1'b0, "no grant from idle lines");
        end
        for (int i = 0; i < 4; i++) begin
            queue_op = i[1:0];
            step();
            chk(queue_track_status, i[1:0], "queue status");
        end
        queue_op = QS_NOP;
        for (int t = 0; t < 7; t++) begin
            run_cycle(t[2:0]);
            chk(status_low_line, 1'b1, "low line high in max mode");
        end
        ready_pin = 1'b0;
        repeat (4) step();
        fork
            run_cycle(3'h4);
            begin
                repeat (6) step();
                chk(cyc_end, 1'b0, "cycle held in wait");
                chk(bus_cycle_status, ST_PASSIVE, "status passive in wait");
                ready_pin = 1'b1;
            end
        join
        $display("test basic done");
    endtask
    task automatic t_grant();
        p_start = 1'b1;
        step();
        p_start = 1'b0;
        serve(1'b0);
        s_start = 1'b1;
        step();
        s_start = 1'b0;
        serve(1'b1);
        p_start = 1'b1;
        s_start = 1'b1;
        step();
        p_start = 1'b0;
        s_start = 1'b0;
        serve(1'b0);
        serve(1'b1);
        $display("test grant done");
    endtask
    task automatic t_lock_and_low_byte();
        int n;
        lock_prefix = 1'b1;
        step();
        lock_prefix = 1'b0;
        chk(lock_n, 1'b0, "lock active");
        p_start = 1'b1;
        step();
        p_start = 1'b0;
        repeat (6) begin
            step();
            chk(hold_ack_out, 1'b0, "no grant while locked");
        end
        instr_done = 1'b1;
        step();
        instr_done = 1'b0;
        chk(lock_n, 1'b1, "lock released");
        serve(1'b0);
        for (int k = 0; k < 2; k++) begin
            cyc_type = 3'h4;
            cyc_low_byte = (k == 0);
            cyc_first_interrupt_ack_strobe = (k == 1);
            cyc_req = 1'b1;
            n = 0;
            step();
            while (cyc_ack !== 1'b1 && n < 12) begin step(); n++; end
            cyc_low_byte = 1'b0;
            cyc_first_interrupt_ack_strobe = 1'b0;
            p_start = 1'b1;
            step();
            p_start = 1'b0;
            n = 0;
            while (cyc_ack !== 1'b1 && n < 20) begin
                chk(hold_ack_out, 1'b0, "no release in blocked cycle");
                step();
                n++;
            end
            cyc_req = 1'b0;
            chk(cyc_ack, 1'b1, "second cycle taken");
            serve(1'b0);
        end
        $display("test lock and low byte done");
    endtask
    task automatic t_min_mode();
        do_reset(1'b1);
        run_cycle(3'h5);
        chk(status_low_line, 1'b1, "low line odd type");
        chk(io_mem_sel, 1'b0, "io select");
        chk(transmit_receive_dir, 1'b0, "direction");
        run_cycle(3'h2);
        chk(status_low_line, 1'b0, "low line even type");
        chk(io_mem_sel, 1'b1, "io select");
        chk(transmit_receive_dir, 1'b1, "direction");
        $display("test min mode done");
    endtask

    //------------------------------------------------------------
    // Main sequence and watchdog
    //------------------------------------------------------------
    initial begin
        {cyc_req, cyc_low_byte, cyc_first_interrupt_ack_strobe, lock_prefix, instr_done} = 5'h00;
        {p_start, s_start} = 2'h0;
        cyc_type = 3'h0;
        queue_op = QS_NOP;
        ready_pin = 1'b1;
        do_reset(1'b0);
        t_basic();
        t_grant();
        t_lock_and_low_byte();
        t_min_mode();
        give_verdict();
    end
    initial begin
        #(6000 * 5);
        err_count++;
        $display("wrong value at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
